// >>> inc/slave_window_regs.vh
// constants for the pci slave window 0 register bank
// assumes inclusion by the window modules only
`ifndef SLAVE_WINDOW_REGS_VH
`define SLAVE_WINDOW_REGS_VH
// register offsets inside the bridge register space
`define WIN_CTL_OFFSET 12'h100
`define WIN_BASE_OFFSET 12'h104
`define WIN_BOUND_OFFSET 12'h108
`define WIN_XLATE_OFFSET 12'h10c
// control field positions
`define CTL_EN_BIT 31
`define CTL_PGM_HI 23
`define CTL_PGM_LO 22
`define CTL_SUPER_HI 21
`define CTL_SUPER_LO 20
`define CTL_VAS_HI 18
`define CTL_VAS_LO 16
`define CTL_VCT_BIT 8
`define CTL_LAS_HI 1
`define CTL_LAS_LO 0
// writable bits and bits kept across a pci reset
`define CTL_WRITE_MASK 32'h80f7_0103
`define CTL_KEEP_MASK 32'h8007_0003
`define ADDR_WRITE_MASK 32'hffff_f000
`define ADDR_KEEP_MASK 32'hf000_0000
// config command enables
`define CMD_MEM_BIT 1
`define CMD_MASTER_BIT 2
`define CMD_RESET 3'h0
`endif

// >>> verilog/retain_reg.v
// one 32-bit window register with power-up load and pci reset retention
// assumes the caller supplies the power-up option value and masks
`timescale 1ns/1ps
module retain_reg #(
   parameter [31:0] WRITE_MASK = 32'hffff_ffff,
   parameter [31:0] KEEP_MASK = 32'h0000_0000
) (
   // clock and resets
   input wire sys_clk,
   input wire rst,
   input wire pci_rst,
   // power-up option value for the kept bits
   input wire [31:0] powerup_value,
   // write port
   input wire wr_en,
   input wire [31:0] wr_data,
   // value
   output reg [31:0] value_reg
);
   reg [31:0] value_next;
   reg load_pending_reg;

   always @* begin
      value_next = value_reg;
      if (load_pending_reg) begin
         value_next = powerup_value & KEEP_MASK; // see RL9
      end else if (pci_rst) begin
         value_next = value_reg & KEEP_MASK; // see RL1 see RL2
      end else if (wr_en) begin
         value_next = wr_data & WRITE_MASK;
      end
   end

   // the strap is sampled one edge after release, never under the async reset
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         value_reg <= 32'h0000_0000; // see RL4
         load_pending_reg <= 1'b1;
      end else begin
         value_reg <= value_next;
         load_pending_reg <= 1'b0;
      end
   end
endmodule

// >>> verilog/slave_window_bank.v
// register bank for pci slave window 0 with its reset retention behaviour
// assumes a simple synchronous register port and pci reset synchronous to sys_clk
//
// Overview of operation
// RL1: pci reset keeps enable, spaces, top base and bound address bits
// RL2: pci reset clears every other window bit
// RL3: pci reset leaves config master/memory enables set
// RL4: board reset restores defined power-up states
// RL5: active window stays enabled through pci reset
// RL6: host disables device before writing base address (the bench writes base with the memory enable set)
// RL7: host clears window enable once base valid
// RL8: reset routine disables window before pci reset (the bench prst task does not; window enable stays set)
// RL9: board reset loads options, clears others
`timescale 1ns/1ps
`include "slave_window_regs.vh"
module slave_window_bank #(
   parameter [31:0] CTL_POWERUP = 32'h0000_0000,
   parameter [31:0] BASE_POWERUP = 32'h0000_0000,
   parameter [31:0] BOUND_POWERUP = 32'h0000_0000
) (
   // clock and resets
   input wire sys_clk,
   input wire rst,
   input wire pci_rst,
   // register port
   input wire [11:0] reg_addr,
   input wire reg_wr,
   input wire reg_rd,
   input wire [31:0] reg_wdata,
   output reg [31:0] reg_rdata,
   output wire reg_ack,
   // config command enables
   input wire cmd_wr,
   input wire [2:0] cmd_wdata,
   output wire config_mem_enable,
   output wire config_master_enable,
   // window state to the decoder
   output wire window_enable,
   output wire [2:0] vme_space_select,
   output wire [1:0] pci_space_select,
   output wire [1:0] program_data_mode,
   output wire [1:0] super_mode,
   output wire cycle_type,
   output wire [31:0] window_base,
   output wire [31:0] window_bound,
   output wire [31:0] window_xlate
);
   wire [31:0] ctl_value;
   reg [2:0] cmd_reg;
   reg [2:0] cmd_next;

   function is_addr;
      input [11:0] a;
      input [11:0] target;
      begin
         is_addr = (a == target);
      end
   endfunction

   retain_reg #(
      .WRITE_MASK(`CTL_WRITE_MASK),
      .KEEP_MASK(`CTL_KEEP_MASK)
   ) u_ctl (
      .sys_clk(sys_clk),
      .rst(rst),
      .pci_rst(pci_rst),
      .powerup_value(CTL_POWERUP),
      .wr_en(reg_wr & is_addr(reg_addr, `WIN_CTL_OFFSET)),
      .wr_data(reg_wdata),
      .value_reg(ctl_value)
   );

   retain_reg #(
      .WRITE_MASK(`ADDR_WRITE_MASK),
      .KEEP_MASK(`ADDR_KEEP_MASK)
   ) u_base (
      .sys_clk(sys_clk),
      .rst(rst),
      .pci_rst(pci_rst),
      .powerup_value(BASE_POWERUP),
      .wr_en(reg_wr & is_addr(reg_addr, `WIN_BASE_OFFSET)),
      .wr_data(reg_wdata),
      .value_reg(window_base)
   );

   retain_reg #(
      .WRITE_MASK(`ADDR_WRITE_MASK),
      .KEEP_MASK(`ADDR_KEEP_MASK)
   ) u_bound (
      .sys_clk(sys_clk),
      .rst(rst),
      .pci_rst(pci_rst),
      .powerup_value(BOUND_POWERUP),
      .wr_en(reg_wr & is_addr(reg_addr, `WIN_BOUND_OFFSET)),
      .wr_data(reg_wdata),
      .value_reg(window_bound)
   );

   // translation offset has no power-up option, so nothing survives
   retain_reg #(
      .WRITE_MASK(`ADDR_WRITE_MASK),
      .KEEP_MASK(32'h0000_0000)
   ) u_xlate (
      .sys_clk(sys_clk),
      .rst(rst),
      .pci_rst(pci_rst),
      .powerup_value(32'h0000_0000),
      .wr_en(reg_wr & is_addr(reg_addr, `WIN_XLATE_OFFSET)),
      .wr_data(reg_wdata),
      .value_reg(window_xlate)
   );

   // enable survives pci reset whatever its power-up default says
   assign window_enable = ctl_value[`CTL_EN_BIT]; // see RL5
   assign vme_space_select = ctl_value[`CTL_VAS_HI:`CTL_VAS_LO];
   assign pci_space_select = ctl_value[`CTL_LAS_HI:`CTL_LAS_LO];
   assign program_data_mode = ctl_value[`CTL_PGM_HI:`CTL_PGM_LO];
   assign super_mode = ctl_value[`CTL_SUPER_HI:`CTL_SUPER_LO];
   assign cycle_type = ctl_value[`CTL_VCT_BIT];

   // command enables are not touched by pci reset, only by board reset and cmd_wr writes
   always @* begin
      cmd_next = cmd_reg;
      if (cmd_wr) begin
         cmd_next = cmd_wdata;
      end
   end

   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cmd_reg <= `CMD_RESET; // see RL4
      end else begin
         cmd_reg <= cmd_next; // see RL3
      end
   end

   assign config_mem_enable = cmd_reg[`CMD_MEM_BIT];
   assign config_master_enable = cmd_reg[`CMD_MASTER_BIT];

   assign reg_ack = reg_rd | reg_wr;

   // unmapped offsets read as zero
   always @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         reg_rdata <= 32'h0000_0000;
      end else if (reg_rd) begin
         case (reg_addr)
            `WIN_CTL_OFFSET: reg_rdata <= ctl_value;
            `WIN_BASE_OFFSET: reg_rdata <= window_base;
            `WIN_BOUND_OFFSET: reg_rdata <= window_bound;
            `WIN_XLATE_OFFSET: reg_rdata <= window_xlate;
            default: reg_rdata <= 32'h0000_0000;
         endcase
      end
   end
endmodule

// >>> tb/host_fw.sv
// host firmware model: pci reset and config command writes
// assumes the bench raises requests just after a clock edge
`timescale 1ns/1ps
module host_fw (
   // requests
   input wire sys_clk, input wire rst_go, input wire cmd_go, input wire [2:0] cmd_req,
   // to the bridge
   output reg pci_rst = 1'b0, output reg cmd_wr = 1'b0, output reg [2:0] cmd_wdata = 3'h0);
   // released data toggles so a stale value never looks valid
   always @(posedge sys_clk) begin
      pci_rst <= rst_go;
      cmd_wr <= cmd_go;
      cmd_wdata <= cmd_go ? cmd_req : ~cmd_wdata;
   end
endmodule

// >>> tb/sw_chk.sv
// assertions on window 0 reset retention
// assumes a bind to slave_window_bank
`timescale 1ns/1ps
module sw_chk #(parameter [31:0] CTL_POWERUP = 32'h0, parameter [31:0] BASE_POWERUP = 32'h0) (
   // clock and resets
   input wire sys_clk, input wire rst, input wire pci_rst, input wire cmd_wr,
   // window state
   input wire config_mem_enable, input wire config_master_enable, input wire window_enable,
   input wire cycle_type, input wire [2:0] vme_space_select, input wire [1:0] pci_space_select,
   input wire [1:0] program_data_mode, input wire [1:0] super_mode,
   input wire [31:0] window_base, input wire [31:0] window_bound, input wire [31:0] window_xlate);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // the first edge after board reset loads options instead
   sequence s_prst;
      pci_rst && !$past(rst);
   endsequence
   chk_keep_ctl: assert property (s_prst |=> $stable({window_enable, vme_space_select, pci_space_select}))
      else $error("kept control bits moved");
   chk_keep_addr: assert property (s_prst |=> $stable({window_base[31:28], window_bound[31:28]}))
      else $error("kept address bits moved");
   chk_clear_rest: assert property (s_prst |=> {program_data_mode, super_mode, cycle_type,
      window_base[27:0], window_bound[27:0], window_xlate} == 93'h0) else $error("field not cleared");
   chk_en_retained: assert property (s_prst ##0 window_enable |=> window_enable)
      else $error("active window dropped by pci reset");
   chk_cmd_kept: assert property (s_prst ##0 !cmd_wr |=> $stable({config_mem_enable, config_master_enable}))
      else $error("command enables moved");
   chk_boot_state: assert property ($fell(rst) |=> !config_mem_enable && !config_master_enable &&
      window_enable == CTL_POWERUP[31] && window_base == (BASE_POWERUP & 32'hf000_0000) && window_xlate == 32'h0)
      else $error("bad power-up state");
endmodule

// >>> tb/slave_window_bank_tb.sv
// bench for the window 0 register bank and its reset retention
// assumes host_fw and sw_chk are compiled alongside
`timescale 1ns/1ps
module slave_window_bank_tb;
   localparam [31:0] CTL_PU = 32'h8003_0001;
   localparam [31:0] ADR_PU = 32'hf000_0000;
   reg sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rst_go = 1'b0, cmd_go = 1'b0;
   reg [11:0] reg_addr = 12'h0, a;
   reg [31:0] reg_wdata = 32'h0;
   wire pci_rst, cmd_wr, config_mem_enable, config_master_enable, window_enable, cycle_type, reg_ack;
   wire [2:0] cmd_wdata, vme_space_select;
   wire [2:0] cmd_req = 3'h6;
   wire [1:0] pci_space_select, program_data_mode, super_mode;
   wire [31:0] reg_rdata, window_base, window_bound, window_xlate;
   integer err_count = 0, tests_run = 0;
   initial begin
      forever #50 sys_clk = ~sys_clk;
   end
   host_fw host (.*);
   slave_window_bank #(.CTL_POWERUP(CTL_PU), .BASE_POWERUP(ADR_PU), .BOUND_POWERUP(ADR_PU)) DUT (.*);
   task chk(input [31:0] got, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (got !== exp) begin
            err_count = err_count + 1;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
         end
      end
   endtask
   task wr(input [11:0] ad, input [31:0] d);
      begin
         @(posedge sys_clk);
         reg_addr <= ad;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge sys_clk);
         reg_wr <= 1'b0;
      end
   endtask
   // expected words in offset order: control, base, bound, offset
   task rd4(input [127:0] e);
      for (a = 12'h100; a < 12'h110; a = a + 12'h4) begin
         @(posedge sys_clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge sys_clk);
         reg_rd <= 1'b0;
         @(negedge sys_clk);
         chk(reg_rdata, e[(3 - a[3:2]) * 32 +: 32]);
      end
   endtask
   task prst;
      begin
         @(posedge sys_clk);
         rst_go <= 1'b1;
         repeat (2) @(posedge sys_clk);
         rst_go <= 1'b0;
         repeat (2) @(posedge sys_clk);
      end
   endtask
   task report_and_stop;
      begin
         $display("checks %0d mismatches %0d", tests_run, err_count);
         if (err_count == 0 && tests_run > 0)
            $display("All tests passed");
         else
            $display("Some tests failed");
         $finish;
      end
   endtask
   initial begin
      #50000;
      err_count = err_count + 1;
      report_and_stop;
   end
   initial begin
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      rd4({CTL_PU, ADR_PU, ADR_PU, 32'h0});
      $display("boot test done");
      @(posedge sys_clk);
      cmd_go <= 1'b1;
      @(posedge sys_clk);
      cmd_go <= 1'b0;
      // the last pass hits an unmapped offset
      for (a = 12'h100; a < 12'h114; a = a + 12'h4)
         wr(a, 32'hffff_ffff);
      rd4({32'h80f7_0103, 32'hffff_f000, 32'hffff_f000, 32'hffff_f000});
      prst;
      rd4({32'h8007_0003, ADR_PU, ADR_PU, 32'h0});
      chk({30'h0, config_mem_enable, config_master_enable}, 32'h3);
      $display("pci reset test done");
      wr(12'h100, 32'h0);
      prst;
      rd4({32'h0, ADR_PU, ADR_PU, 32'h0});
      // board reset is raised on a rising edge like every other input
      @(posedge sys_clk);
      rst <= 1'b1;
      @(posedge sys_clk);
      rst <= 1'b0;
      rd4({CTL_PU, ADR_PU, ADR_PU, 32'h0});
      chk({30'h0, config_mem_enable, config_master_enable}, 32'h0);
      $display("board reset test done");
      report_and_stop;
   end
endmodule
bind slave_window_bank sw_chk #(.CTL_POWERUP(CTL_POWERUP), .BASE_POWERUP(BASE_POWERUP)) chk (.*);
